// [opp_pkg.sv]
/*
 * Package for the one-time PROM programming and verify port:
 * timing counts, area maps, register offsets and carrier types.
 * Assumes a single 40 MHz clock and an 8-bit data path.
 */
package opp_pkg;

    // Clock and program pulse timing
    localparam int unsigned CLK_MHZ   = 40;
    localparam int unsigned PULSE_NS  = 100000;
    localparam int unsigned PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned MAX_TRIES = 25;

    // Address widths of the two views and of the linear array
    localparam int unsigned MCU_AW = 20;
    localparam int unsigned PRM_AW = 17;
    localparam int unsigned LIN_AW = 17;

    // Area bounds in MCU mode
    localparam logic [19:0] MCU_PGM_LO  = 20'h04000;
    localparam logic [19:0] MCU_PGM_HI  = 20'h13eff;
    localparam logic [19:0] MCU_FONT_LO = 20'h20000;
    localparam logic [19:0] MCU_FONT_HI = 20'h25fff;
    localparam logic [19:0] MCU_VEC_LO  = 20'hfff00;
    localparam logic [19:0] MCU_VEC_HI  = 20'hfffff;

    // Area bounds in PROM mode
    localparam logic [16:0] PRM_PGM_LO  = 17'h10000;
    localparam logic [16:0] PRM_PGM_HI  = 17'h1feff;
    localparam logic [16:0] PRM_FONT_LO = 17'h0a000;
    localparam logic [16:0] PRM_FONT_HI = 17'h0ffff;
    localparam logic [16:0] PRM_VEC_LO  = 17'h1ff00;
    localparam logic [16:0] PRM_VEC_HI  = 17'h1ffff;

    // Linear array layout: program, vector, font
    localparam logic [16:0] LIN_PGM   = 17'h00000;
    localparam logic [16:0] LIN_VEC   = 17'h0ff00;
    localparam logic [16:0] LIN_FONT  = 17'h10000;
    localparam int unsigned MEM_DEPTH = 32'h16000;

    // Values and register map on the software port
    localparam logic [7:0]  ERASED      = 8'hff;
    localparam logic [19:0] REG_STAT    = 20'h00f80;
    localparam logic [19:0] REG_CTRL    = 20'h00f81;
    localparam int unsigned CTRL_LOCK   = 0;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam int unsigned STAT_MODE   = 0;
    localparam int unsigned STAT_LOCK   = 1;
    localparam int unsigned STAT_OVER   = 2;
    localparam int unsigned STAT_TRY_LO = 3;

    // Pins seen from the programmer socket
    typedef struct packed {
        logic [16:0] addr;
        logic [7:0]  data;
        logic        ce_n;
        logic        oe_n;
        logic        pgm_n;
        logic        vpp;
        logic        p70;
        logic        p71;
        logic        p20;
        logic        p31;
        logic        p34;
        logic        reset_pin;
    } opp_pins_t;

    localparam opp_pins_t PINS_IDLE = '{addr: 17'h00000, data: 8'hff, ce_n: 1'b1,
        oe_n: 1'b1, pgm_n: 1'b1, vpp: 1'b0, p70: 1'b0, p71: 1'b0, p20: 1'b0,
        p31: 1'b0, p34: 1'b0, reset_pin: 1'b0};

    // Result of an address lookup
    typedef struct packed {
        logic        hit;
        logic [16:0] idx;
    } opp_map_t;

endpackage

// [opp_prog_model.sv]
/* Programmer model driving the socket pins.
   Assumes the testbench calls its tasks; pins change after rising edges. */
`timescale 1ns/1ps
module opp_prog_model
    import opp_pkg::*;
(
    // Clock
    input  wire logic       i_clk,
    // Device data return
    input  wire logic [7:0] i_data,
    input  wire logic       i_data_oe_n,
    // Socket pins
    output opp_pins_t       o_pins
);
    initial o_pins = PINS_IDLE;
    // Set the socket pins, then hold them n cycles; vpp and p70 keep their level, other setting pins go low
    task automatic drive(input logic [16:0] a, input logic [7:0] d, input logic ce_n, oe_n,
        pgm_n, input int n);
        @(posedge i_clk);
        o_pins <= '{addr: a, data: d, ce_n: ce_n, oe_n: oe_n, pgm_n: pgm_n, vpp: o_pins.vpp,
            p70: o_pins.p70, default: 1'b0};
        repeat (n) @(posedge i_clk);
    endtask
    // Enter or leave PROM mode
    task automatic mode(input logic on);
        @(posedge i_clk);
        o_pins.vpp <= on;
        o_pins.p70 <= on;
        repeat (6) @(posedge i_clk);
    endtask
    // Verify read; own data lines show the inverse while released
    task automatic rdb(input logic [16:0] a, output logic [7:0] q);
        drive(a, ~o_pins.data, 1'b0, 1'b0, 1'b1, 8);
        q = i_data_oe_n ? 8'hxx : i_data;
        drive(a, ~o_pins.data, 1'b1, 1'b1, 1'b1, 4);
    endtask
    // Pulse and verify until the byte matches or lim pulses are spent
    task automatic prog(input logic [16:0] a, input logic [7:0] d, input int w, lim,
        output int n);
        logic [7:0] q;
        n = 0;
        q = ~d;
        while (q !== d && n < lim) begin
            drive(a, d, 1'b0, 1'b1, 1'b1, 2);
            drive(a, d, 1'b0, 1'b1, 1'b0, w);
            drive(a, d, 1'b0, 1'b1, 1'b1, 6);
            n++;
            rdb(a, q);
        end
    endtask
endmodule // opp_prog_model

// [opp_prom_port.sv]
/*
 * One-time PROM array with its parallel programming and verify port
 * and the read port used by the core in MCU mode.
 * Assumes socket pins are asynchronous to i_clk and that the core
 * port is a plain strobe bus on i_clk with read data one cycle later.
 */
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - Program area: 04000H-13EFFH in MCU mode, 10000H-1FEFFH in PROM mode.
// - Font area: 20000H-25FFFH in MCU mode, 0A000H-0FFFFH in PROM mode.
// - Vector area: FFF00H-FFFFFH in MCU mode, 1FF00H-1FFFFH in PROM mode.
// - Chip enable is active low; socket reads and program pulses act only while it is low.
// - Output enable is active low; data driven only while it is low.
// - No electronic signature readout; only array contents are returned.
module opp_prom_port
    import opp_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = PULSE_CYC,
    parameter int unsigned TRY_LIMIT    = MAX_TRIES
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // Programmer socket pins
    input  wire opp_pins_t         i_pins,
    output logic [7:0]             o_data,
    output logic                   o_data_oe_n,
    // Core read and register port
    input  wire logic [MCU_AW-1:0] i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [7:0]             o_rdata,
    // Mode indication
    output logic                   o_prom_mode
);

    // Map a PROM-mode address onto the linear array
    function automatic opp_map_t prom_map(input logic [16:0] a);
        opp_map_t m;
        m = '{hit: 1'b0, idx: 17'h00000};
        if (a >= PRM_PGM_LO && a <= PRM_PGM_HI) begin
            m = '{hit: 1'b1, idx: a - PRM_PGM_LO + LIN_PGM};
        end else if (a >= PRM_FONT_LO && a <= PRM_FONT_HI) begin
            m = '{hit: 1'b1, idx: a - PRM_FONT_LO + LIN_FONT};
        end else if (a >= PRM_VEC_LO) begin
            m = '{hit: 1'b1, idx: a - PRM_VEC_LO + LIN_VEC};
        end
        return m;
    endfunction

    // Map an MCU-mode address onto the linear array
    function automatic opp_map_t mcu_map(input logic [19:0] a);
        opp_map_t m;
        logic [19:0] off;
        m = '{hit: 1'b0, idx: 17'h00000};
        off = 20'h00000;
        if (a >= MCU_PGM_LO && a <= MCU_PGM_HI) begin
            off = a - MCU_PGM_LO;
            m = '{hit: 1'b1, idx: off[16:0] + LIN_PGM};
        end else if (a >= MCU_FONT_LO && a <= MCU_FONT_HI) begin
            off = a - MCU_FONT_LO;
            m = '{hit: 1'b1, idx: off[16:0] + LIN_FONT};
        end else if (a >= MCU_VEC_LO && a <= MCU_VEC_HI) begin
            off = a - MCU_VEC_LO;
            m = '{hit: 1'b1, idx: off[16:0] + LIN_VEC};
        end
        return m;
    endfunction

    // Program pulse states
    typedef enum logic [1:0] {
        OPP_IDLE,
        OPP_PULSE,
        OPP_COMMIT
    } opp_state_t;

    // OTP cells, erased to all ones
    logic [7:0]  mem [MEM_DEPTH];

    // Synchronised pins, latched pulse context and status
    opp_pins_t   meta_q;
    opp_pins_t   pins_q;
    logic        mode_q;
    logic [7:0]  data_q;
    logic        data_oe_n_q;
    logic [7:0]  rdata_q;
    logic [7:0]  ctrl_q;
    opp_state_t  state_q;
    logic [12:0] width_q;
    logic [16:0] lat_addr_q;
    logic [7:0]  lat_data_q;
    logic [16:0] last_addr_q;
    logic [4:0]  tries_q;
    logic        over_q;
    logic        mode_d;
    logic        prog_req;
    logic        rd_req;
    logic        pulse_ok;
    logic        new_byte;
    opp_map_t    pmap;
    opp_map_t    lmap;
    opp_map_t    cmap;
    logic [7:0]  stat;

    initial begin
        for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] = ERASED;
        end
    end

    // Two-stage synchroniser for all socket pins
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_q <= PINS_IDLE;
            pins_q <= PINS_IDLE;
        end else begin
            meta_q <= i_pins;
            pins_q <= meta_q;
        end
    end

    // Mode decode from the strap pins
    always_comb begin
        mode_d = pins_q.vpp;
        mode_d = mode_d & pins_q.p70;
        mode_d = mode_d & ~(pins_q.p71 | pins_q.p20 | pins_q.p31
                            | pins_q.p34 | pins_q.reset_pin);
    end

    // Registered mode, held low through reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mode_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Socket cycle qualifiers
    assign pmap     = prom_map(pins_q.addr);
    assign lmap     = prom_map(lat_addr_q);
    assign rd_req   = mode_q & ~pins_q.ce_n & ~pins_q.oe_n
                      & pins_q.pgm_n;
    assign prog_req = mode_q & ~pins_q.ce_n & pins_q.oe_n
                      & ~pins_q.pgm_n & ~ctrl_q[CTRL_LOCK];
    assign pulse_ok = (32'(width_q) >= PULSE_CYCLES);
    assign new_byte = (pins_q.addr != last_addr_q);

    // Program pulse sequencer
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_q <= OPP_IDLE;
        end else begin
            case (state_q)
                OPP_IDLE: begin
                    if (prog_req) begin
                        state_q <= OPP_PULSE;
                    end
                end
                OPP_PULSE: begin
                    if (!prog_req) begin
                        state_q <= pulse_ok ? OPP_COMMIT : OPP_IDLE;
                    end
                end
                OPP_COMMIT: begin
                    state_q <= OPP_IDLE;
                end
                default: begin
                    state_q <= OPP_IDLE;
                end
            endcase
        end
    end

    // Pulse width counter, saturating at the pulse length
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            width_q <= 13'h0000;
        end else if (state_q == OPP_PULSE && prog_req) begin
            if (!pulse_ok) begin
                width_q <= width_q + 13'h0001;
            end
        end else begin
            width_q <= 13'h0000;
        end
    end

    // Address and data captured each cycle the pulse is applied, then held
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lat_addr_q <= 17'h00000;
            lat_data_q <= ERASED;
        end else if (prog_req) begin
            lat_addr_q <= pins_q.addr;
            lat_data_q <= pins_q.data;
        end
    end

    // Cell write: only ones may be cleared in an OTP cell
    // Plain always, since the erased fill shares the array
    always @(posedge i_clk) begin
        if (state_q == OPP_COMMIT && lmap.hit) begin
            mem[lmap.idx] <= mem[lmap.idx] & lat_data_q;
        end
    end

    // Full-length pulses (at least PULSE_CYCLES) applied to the current byte
    // Counter saturates so a runaway programmer cannot wrap it
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            last_addr_q <= 17'h00000;
            tries_q     <= 5'h00;
        end else if (state_q == OPP_IDLE && prog_req && new_byte) begin
            last_addr_q <= pins_q.addr;
            tries_q     <= 5'h00;
        end else if (state_q == OPP_COMMIT && tries_q != 5'h1f) begin
            tries_q     <= tries_q + 5'h01;
        end
    end

    // Sticky flag: more pulses than allowed on one byte
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            over_q <= 1'b0;
        end else if (state_q == OPP_COMMIT && 32'(tries_q) >= TRY_LIMIT) begin
            over_q <= 1'b1;
        end else if (state_q == OPP_IDLE && prog_req && new_byte) begin
            over_q <= 1'b0;
        end
    end

    // Verify read onto the socket data bus
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            data_q      <= ERASED;
            data_oe_n_q <= 1'b1;
        end else begin
            data_oe_n_q <= ~rd_req;
            data_q      <= pmap.hit ? mem[pmap.idx] : ERASED;
        end
    end

    // Control register written by the core
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (i_wr && i_addr == REG_CTRL) begin
            ctrl_q <= {7'h00, i_wdata[CTRL_LOCK]};
        end
    end

    // Status seen by the core
    always_comb begin
        stat              = 8'h00;
        stat[STAT_MODE]   = mode_q;
        stat[STAT_LOCK]   = ctrl_q[CTRL_LOCK];
        stat[STAT_OVER]   = over_q;
        stat[7:STAT_TRY_LO] = tries_q;
    end

    // Core address decode for array reads
    assign cmap = mcu_map(i_addr);

    // Core read port, data valid the cycle after the strobe
    // Array hidden from the core while the socket owns it
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
        end else if (!i_rd) begin
            rdata_q <= 8'h00;
        end else if (i_addr == REG_STAT) begin
            rdata_q <= stat;
        end else if (i_addr == REG_CTRL) begin
            rdata_q <= ctrl_q;
        end else if (cmap.hit && !mode_q) begin
            rdata_q <= mem[cmap.idx];
        end else begin
            rdata_q <= ERASED;
        end
    end

    // Outputs straight from flops
    assign o_data      = data_q;
    assign o_data_oe_n = data_oe_n_q;
    assign o_rdata     = rdata_q;
    assign o_prom_mode = mode_q;

endmodule // opp_prom_port

// [opp_prom_port_monitor.sv]
/* Checker for the PROM programming port, bound to opp_prom_port.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
module opp_prom_port_monitor
    import opp_pkg::*;
(
    // Clock and reset
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    // Socket side
    input wire opp_pins_t         i_pins,
    input wire logic [7:0]        o_data,
    input wire logic              o_data_oe_n,
    // Core side
    input wire logic [MCU_AW-1:0] i_addr,
    input wire logic [7:0]        i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [7:0]        o_rdata,
    input wire logic              o_prom_mode
);
    // Decoded socket conditions
    logic mode_pins;
    logic rd_cyc;
    assign mode_pins = i_pins.vpp & i_pins.p70 & ~(i_pins.p71 | i_pins.p20 | i_pins.p31
        | i_pins.p34 | i_pins.reset_pin);
    assign rd_cyc = ~i_pins.ce_n & ~i_pins.oe_n & i_pins.pgm_n;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_mode_entry: assert property (mode_pins [*5] |-> o_prom_mode)
        else $error("prom mode not entered");
    a_mode_exit: assert property (!i_pins.vpp [*5] |-> !o_prom_mode)
        else $error("prom mode kept with low vpp");
    a_mode_cause: assert property ($rose(o_prom_mode) |-> $past(mode_pins, 2))
        else $error("prom mode without setting pins");
    a_ce_release: assert property (i_pins.ce_n [*5] |-> o_data_oe_n)
        else $error("data driven with chip enable high");
    a_oe_release: assert property (i_pins.oe_n [*5] |-> o_data_oe_n)
        else $error("data driven with output enable high");
    a_read_drive: assert property ((o_prom_mode && rd_cyc) [*6] |-> !o_data_oe_n)
        else $error("verify read not driven");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_prom_rd_ff: assert property ((i_rd && o_prom_mode && i_addr >= MCU_PGM_LO
        && i_addr <= MCU_PGM_HI) |=> o_rdata == ERASED)
        else $error("array visible to core in prom mode");
    a_gap_rd_ff: assert property ((i_rd && i_addr >= 20'h14000 && i_addr <= 20'h1ffff)
        |=> o_rdata == ERASED)
        else $error("unmapped core read not erased");
endmodule // opp_prom_port_monitor

bind opp_prom_port opp_prom_port_monitor opp_prom_port_monitor_i (.i_clk, .i_rst_n,
    .i_pins, .o_data, .o_data_oe_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_prom_mode);

// [opp_prom_port_tb_top.sv]
/* Self-checking testbench for opp_prom_port with a programmer model.
   Assumes a 40 MHz clock and a shortened program pulse count. */
`timescale 1ns/1ps
module opp_prom_port_tb_top
    import opp_pkg::*;
;
    logic              i_clk;
    logic              i_rst_n;
    logic              i_wr;
    logic              i_rd;
    logic [MCU_AW-1:0] i_addr;
    logic [7:0]        i_wdata;
    opp_pins_t         pins;
    logic [7:0]        o_data;
    logic [7:0]        o_rdata;
    logic              o_data_oe_n;
    logic              o_prom_mode;
    int                fails;
    int                checks;
    int                n;
    logic [7:0]        q;
    logic [16:0]       pa [6] = '{17'h10000, 17'h1feff, 17'h0a000, 17'h0ffff, 17'h1ff00, 17'h1ffff};
    logic [19:0]       ma [6] = '{20'h04000, 20'h13eff, 20'h20000, 20'h25fff, 20'hfff00, 20'hfffff};

    // Clock, kept running through the whole run
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    opp_prom_port #(.PULSE_CYCLES(20), .TRY_LIMIT(25)) opp_prom_port_i (.i_clk, .i_rst_n,
        .i_pins(pins), .o_data, .o_data_oe_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .o_prom_mode);
    opp_prog_model opp_prog_model_i (.i_clk, .i_data(o_data), .i_data_oe_n(o_data_oe_n),
        .o_pins(pins));

    // Byte compare
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Core bus write and read
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Reset values
    task automatic t_reset();
        chk("mode", 8'h00, {7'h00, o_prom_mode});
        chk("oe", 8'h01, {7'h00, o_data_oe_n});
        rd(REG_CTRL, q);
        chk("ctrl", CTRL_RESET, q);
    endtask
    // Area bounds programmed in PROM mode, read back in MCU mode
    task automatic t_areas();
        opp_prog_model_i.mode(1'b1);
        for (int i = 0; i < 6; i++) begin
            opp_prog_model_i.prog(pa[i], 8'(8'h3c + i), 24, 25, n);
            chk("tries", 8'h01, 8'(n));
        end
        rd(ma[0], q);
        chk("prom core", ERASED, q);
        opp_prog_model_i.mode(1'b0);
        for (int i = 0; i < 6; i++) begin
            rd(ma[i], q);
            chk("mcu map", 8'(8'h3c + i), q);
        end
        rd(20'h14000, q);
        chk("gap", ERASED, q);
    endtask
    // Short pulse, locked pulse and a read with chip enable high
    task automatic t_refuse();
        opp_prog_model_i.mode(1'b1);
        opp_prog_model_i.prog(17'h10001, 8'h00, 10, 1, n);
        opp_prog_model_i.rdb(17'h10001, q);
        chk("short", ERASED, q);
        wr(REG_CTRL, 8'h01);
        rd(REG_CTRL, q);
        chk("lock", 8'h01, q);
        opp_prog_model_i.prog(17'h10002, 8'h00, 24, 1, n);
        opp_prog_model_i.rdb(17'h10002, q);
        chk("locked", ERASED, q);
        wr(REG_CTRL, 8'h00);
        opp_prog_model_i.drive(17'h10000, 8'hff, 1'b1, 1'b0, 1'b1, 8);
        chk("ce off", 8'h01, {7'h00, o_data_oe_n});
    endtask
    // Byte that never verifies: pulse cap and status
    task automatic t_tries();
        opp_prog_model_i.prog(17'h10000, 8'h5a, 24, 25, n);
        chk("cap", 8'd25, 8'(n));
        opp_prog_model_i.rdb(17'h10000, q);
        chk("cleared", 8'h18, q);
        rd(REG_STAT, q);
        chk("stat", 8'hc9, q);
        opp_prog_model_i.prog(17'h10000, 8'h5a, 24, 1, n);
        rd(REG_STAT, q);
        chk("over", 8'hd5, q);
    endtask

    // Main sequence
    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 20'h00000;
        i_wdata = 8'h00;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_areas();
        t_refuse();
        t_tries();
        test_done();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        test_done();
    end
endmodule // opp_prom_port_tb_top
